/* dct_pkg.sv */
package dct_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int DCT_NCH = 2;
  localparam int DCT_NGEN = 4;
  localparam int DCT_PRE_W = 6;

  // ---------------------------------------------------------------
  // Register word indexes on the internal 16-bit bus
  // ---------------------------------------------------------------
  localparam logic [3:0] DCT_IDX_CNT1 = 4'h0;
  localparam logic [3:0] DCT_IDX_GEN0 = 4'h2;
  localparam logic [3:0] DCT_IDX_RUN = 4'h6;
  localparam logic [3:0] DCT_IDX_SYNC = 4'h7;
  localparam logic [3:0] DCT_IDX_CTRL1 = 4'h8;
  localparam logic [3:0] DCT_IDX_PIO1 = 4'ha;
  localparam logic [3:0] DCT_IDX_STAT1 = 4'hc;

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [15:0] DCT_CNT_RST = 16'h0000;
  localparam logic [15:0] DCT_CNT_ONE = 16'h0001;
  localparam logic [15:0] DCT_GEN_RST = 16'hffff;
  localparam logic [15:0] DCT_RD_NONE = 16'h0000;
  localparam logic [7:0] DCT_B8_RST = 8'h00;
  localparam logic [7:0] DCT_CH_MASK = 8'h06;
  localparam logic [DCT_PRE_W-1:0] DCT_PRE_ONE = 6'h01;

  // Run and sync bit of channel c sits at bit c+1
  localparam int DCT_CH_BIT0 = 1;

  // ---------------------------------------------------------------
  // Counter control fields
  // ---------------------------------------------------------------
  localparam int DCT_CTL_CKS_LO = 0;
  localparam int DCT_CTL_CLR_LO = 2;
  typedef enum logic [1:0] {
    DCT_CLR_NONE = 2'h0,
    DCT_CLR_CMPA = 2'h1,
    DCT_CLR_CMPB = 2'h2,
    DCT_CLR_SYNC = 2'h3
  } dct_clr_type;

  // ---------------------------------------------------------------
  // Pin I/O control fields, one nibble per general register
  // ---------------------------------------------------------------
  localparam int DCT_IO_W = 4;
  localparam int DCT_IO_INIT = 0;
  localparam int DCT_IO_ACT_LO = 1;
  localparam int DCT_IO_CAP = 3;
  typedef enum logic [1:0] {
    DCT_ACT_HOLD = 2'h0,
    DCT_ACT_LOW = 2'h1,
    DCT_ACT_HIGH = 2'h2,
    DCT_ACT_TOGGLE = 2'h3
  } dct_act_type;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int DCT_ST_FA = 0;
  localparam int DCT_ST_OVF = 4;
  localparam logic [7:0] DCT_ST_RSV_ONES = 8'hc0;

endpackage : dct_pkg

/* dct_sync_bit_ch2.sv */
`timescale 1ns/10ps
module dct_sync_bit_ch2
  import dct_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end

endmodule : dct_sync_bit_ch2

/* dct_chan.sv */
`timescale 1ns/10ps
module dct_chan
  import dct_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic standby,
  input wire logic tick,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic clear,
  output logic [15:0] cnt_q,
  output logic wrap
);

  logic [15:0] cnt_d;

  // ---------------------------------------------------------------
  // Up-counter; a load beats a clear, so a preset is lost only in standby
  // ---------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    wrap = 1'b0;
    if (standby) begin
      cnt_d = DCT_CNT_RST;
    end else if (load) begin
      cnt_d = load_val;
    end else if (clear) begin
      cnt_d = DCT_CNT_RST;
    end else if (run && tick) begin
      cnt_d = cnt_q + DCT_CNT_ONE;
      wrap = (cnt_q == DCT_GEN_RST);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= DCT_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : dct_chan

/* dct_timer.sv */
`timescale 1ns/10ps
// Overview of operation
// - Two channels, each with 16-bit up-counter
// - Counters zero on reset and standby
// - Four general registers: compare or capture
// - General registers reset to all ones
// - Run bits 2,1 start/stop counters
// - I/O control write while stopped sets pin
// - Sync bits 2,1 select synchronous operation
// - Synced counters preset and clear together
// - Sync clear needs sync bit and source
// - Wrap from all ones sets overflow flag
module dct_timer
  import dct_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_standby,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic [DCT_NGEN-1:0] pin_in,
  output logic [DCT_NGEN-1:0] pin_out,
  output logic [DCT_NGEN-1:0] pin_oe
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Count clock: the free prescaler divided by 1, 4, 16 or 64
  // A tick is the one cycle in which the selected low bits are all ones
  function automatic logic dct_tick(input logic [1:0] sel, input logic [DCT_PRE_W-1:0] pre);
    logic t;
    t = 1'b1;
    unique case (sel)
      2'h0: t = 1'b1;
      2'h1: t = &pre[1:0];
      2'h2: t = &pre[3:0];
      2'h3: t = &pre;
    endcase
    return t;
  endfunction : dct_tick

  function automatic logic [DCT_IO_W-1:0] dct_io(input logic [7:0] pio, input int ab);
    return ab[0] ? pio[2*DCT_IO_W-1:DCT_IO_W] : pio[DCT_IO_W-1:0];
  endfunction : dct_io

  function automatic logic [3:0] dct_at(input logic [3:0] base, input int ofs);
    return base + ofs[3:0];
  endfunction : dct_at

  // ---------------------------------------------------------------
  // Pin and standby synchronisers
  // ---------------------------------------------------------------
  logic [DCT_NGEN-1:0] pin_s;
  logic standby_s;

  dct_sync_bit_ch2 #(.WIDTH(DCT_NGEN)) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  dct_sync_bit_ch2 #(.WIDTH(1)) u_stby_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(hw_standby),
    .sync_out(standby_s)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] gen_q [DCT_NGEN];
  logic [15:0] gen_d [DCT_NGEN];
  logic [7:0] run_q, run_d;
  logic [7:0] sync_q, sync_d;
  logic [7:0] ctrl_q [DCT_NCH];
  logic [7:0] ctrl_d [DCT_NCH];
  logic [7:0] pio_q [DCT_NCH];
  logic [7:0] pio_d [DCT_NCH];
  logic [7:0] stat_q [DCT_NCH];
  logic [7:0] stat_d [DCT_NCH];
  logic [DCT_NGEN-1:0] pin_d, oe_d, prev_q, prev_d;
  logic [15:0] rdata_d;
  logic [DCT_PRE_W-1:0] pre_q, pre_d;

  // Counter values, per-channel and per-general-register event strobes
  logic [15:0] cnt [DCT_NCH];
  logic [DCT_NCH-1:0] wrap, tick_ch, run_v, sync_v;
  logic [DCT_NCH-1:0] cnt_wr, load_ch, clr_own, clr_ch;
  logic [DCT_NGEN-1:0] cap_ev, cmp_ev;
  logic wr_full, wr_lo;

  // ---------------------------------------------------------------
  // Channel counters
  // ---------------------------------------------------------------
  for (genvar c = 0; c < DCT_NCH; c++) begin : g_chan
    dct_chan u_chan (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby(standby_s),
      .tick(tick_ch[c]),
      .run(run_v[c]),
      .load(load_ch[c]),
      .load_val(bus_wdata),
      .clear(clr_ch[c]),
      .cnt_q(cnt[c]),
      .wrap(wrap[c])
    );
  end

  // ---------------------------------------------------------------
  // Events: ticks, compare, capture, preset and clear
  // ---------------------------------------------------------------
  always_comb begin
    logic [DCT_IO_W-1:0] io;
    dct_clr_type src;
    int c;
    io = '0;
    src = DCT_CLR_NONE;
    c = 0;
    // 16-bit registers only take full-word writes; byte writes are dropped
    wr_full = bus_wr && (&bus_be);
    wr_lo = bus_wr && bus_be[0];
    for (int n = 0; n < DCT_NCH; n++) begin
      run_v[n] = run_q[n + DCT_CH_BIT0];
      sync_v[n] = sync_q[n + DCT_CH_BIT0];
      tick_ch[n] = dct_tick(ctrl_q[n][DCT_CTL_CKS_LO +: 2], pre_q);
      cnt_wr[n] = wr_full && (bus_addr == dct_at(DCT_IDX_CNT1, n));
    end
    for (int k = 0; k < DCT_NGEN; k++) begin
      c = k / 2;
      io = dct_io(pio_q[c], k % 2);
      // Rising edge only; the pin passed two flops, so it lags by two cycles
      cap_ev[k] = io[DCT_IO_CAP] && pin_s[k] && !prev_q[k];
      // Judged on a count tick only, so a halted counter never matches
      cmp_ev[k] = !io[DCT_IO_CAP] && run_v[c] && tick_ch[c] && (cnt[c] == gen_q[k]);
    end
    for (int n = 0; n < DCT_NCH; n++) begin
      src = dct_clr_type'(ctrl_q[n][DCT_CTL_CLR_LO +: 2]);
      // A capture on the selected register clears the counter as a match does
      clr_own[n] = ((src == DCT_CLR_CMPA) && (cmp_ev[2*n] || cap_ev[2*n]))
                || ((src == DCT_CLR_CMPB) && (cmp_ev[2*n+1] || cap_ev[2*n+1]));
    end
    for (int n = 0; n < DCT_NCH; n++) begin
      src = dct_clr_type'(ctrl_q[n][DCT_CTL_CLR_LO +: 2]);
      // Another synced channel's own clear pulls this one along when its clear source is sync
      clr_ch[n] = clr_own[n] || (sync_v[n] && (src == DCT_CLR_SYNC)
               && |(clr_own & sync_v & ~(DCT_NCH'(1) << n)));
      // A full write to any synced counter presets every synced counter
      load_ch[n] = cnt_wr[n] || (sync_v[n] && |(cnt_wr & sync_v));
    end
  end

  // ---------------------------------------------------------------
  // Register file, pins and read data
  // ---------------------------------------------------------------
  always_comb begin
    logic [DCT_IO_W-1:0] io;
    int c;
    io = '0;
    c = 0;
    gen_d = gen_q;
    run_d = run_q;
    sync_d = sync_q;
    ctrl_d = ctrl_q;
    pio_d = pio_q;
    stat_d = stat_q;
    pin_d = pin_out;
    oe_d = pin_oe;
    rdata_d = bus_rdata;
    prev_d = pin_s;
    pre_d = pre_q + DCT_PRE_ONE;

    // Unused bits are forced to zero so a careless write cannot enable them
    if (wr_lo && bus_addr == DCT_IDX_RUN) begin
      run_d = bus_wdata[7:0] & DCT_CH_MASK;
    end
    if (wr_lo && bus_addr == DCT_IDX_SYNC) begin
      sync_d = bus_wdata[7:0] & DCT_CH_MASK;
    end
    for (int n = 0; n < DCT_NCH; n++) begin
      if (wr_lo && bus_addr == dct_at(DCT_IDX_CTRL1, n)) begin
        ctrl_d[n] = bus_wdata[7:0];
      end
      if (wr_lo && bus_addr == dct_at(DCT_IDX_PIO1, n)) begin
        pio_d[n] = bus_wdata[7:0];
      end
      // Write 0 clears a flag, but a new event in the same cycle wins
      if (wr_lo && bus_addr == dct_at(DCT_IDX_STAT1, n)) begin
        stat_d[n] = stat_q[n] & bus_wdata[7:0];
      end
      // Overflow is the counter's own wrap, never a load or clear to zero
      stat_d[n][DCT_ST_OVF] = stat_d[n][DCT_ST_OVF] | wrap[n];
      for (int ab = 0; ab < 2; ab++) begin
        stat_d[n][DCT_ST_FA + ab] = stat_d[n][DCT_ST_FA + ab]
                                  | cmp_ev[2*n+ab] | cap_ev[2*n+ab];
      end
    end

    for (int k = 0; k < DCT_NGEN; k++) begin
      c = k / 2;
      // Capture beats a software write landing in the same cycle
      if (cap_ev[k]) begin
        gen_d[k] = cnt[c];
      end else if (wr_full && bus_addr == dct_at(DCT_IDX_GEN0, k)) begin
        gen_d[k] = bus_wdata;
      end
      // The new control value decides pin level and enable at once
      io = dct_io(pio_d[c], k % 2);
      if (wr_lo && bus_addr == dct_at(DCT_IDX_PIO1, c) && !run_v[c]) begin
        pin_d[k] = io[DCT_IO_INIT];
      end else if (cmp_ev[k]) begin
        unique case (dct_act_type'(io[DCT_IO_ACT_LO +: 2]))
          DCT_ACT_HOLD: pin_d[k] = pin_out[k];
          DCT_ACT_LOW: pin_d[k] = 1'b0;
          DCT_ACT_HIGH: pin_d[k] = 1'b1;
          DCT_ACT_TOGGLE: pin_d[k] = !pin_out[k];
        endcase
      end
      // With the run bit low no compare event occurs, so the level holds
      oe_d[k] = !io[DCT_IO_CAP]
             && (dct_act_type'(io[DCT_IO_ACT_LO +: 2]) != DCT_ACT_HOLD);
    end

    // Only a read strobe refreshes the read data; it holds otherwise
    // Upper byte of an 8-bit register reads as zero
    if (bus_rd) begin
      rdata_d = DCT_RD_NONE;
      if (bus_addr == DCT_IDX_RUN) begin
        rdata_d[7:0] = run_q;
      end
      if (bus_addr == DCT_IDX_SYNC) begin
        rdata_d[7:0] = sync_q;
      end
      for (int n = 0; n < DCT_NCH; n++) begin
        if (bus_addr == dct_at(DCT_IDX_CNT1, n)) begin
          rdata_d = cnt[n];
        end
        if (bus_addr == dct_at(DCT_IDX_CTRL1, n)) begin
          rdata_d[7:0] = ctrl_q[n];
        end
        if (bus_addr == dct_at(DCT_IDX_PIO1, n)) begin
          rdata_d[7:0] = pio_q[n];
        end
        if (bus_addr == dct_at(DCT_IDX_STAT1, n)) begin
          rdata_d[7:0] = stat_q[n] | DCT_ST_RSV_ONES;
        end
      end
      for (int k = 0; k < DCT_NGEN; k++) begin
        if (bus_addr == dct_at(DCT_IDX_GEN0, k)) begin
          rdata_d = gen_q[k];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int k = 0; k < DCT_NGEN; k++) begin
        gen_q[k] <= DCT_GEN_RST;
      end
      for (int n = 0; n < DCT_NCH; n++) begin
        ctrl_q[n] <= DCT_B8_RST;
        pio_q[n] <= DCT_B8_RST;
        stat_q[n] <= DCT_B8_RST;
      end
      run_q <= DCT_B8_RST;
      sync_q <= DCT_B8_RST;
      pin_out <= '0;
      pin_oe <= '0;
      prev_q <= '0;
      bus_rdata <= DCT_RD_NONE;
      // Prescaler restarts at reset, so divided ticks keep a known phase
      pre_q <= '0;
    end else begin
      gen_q <= gen_d;
      ctrl_q <= ctrl_d;
      pio_q <= pio_d;
      stat_q <= stat_d;
      run_q <= run_d;
      sync_q <= sync_d;
      pin_out <= pin_d;
      pin_oe <= oe_d;
      prev_q <= prev_d;
      bus_rdata <= rdata_d;
      pre_q <= pre_d;
    end
  end

endmodule : dct_timer

/* dct_timer_checker.sv */
`timescale 1ns/10ps
module dct_timer_checker
  import dct_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_standby,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic [DCT_NGEN-1:0] pin_in,
  input wire logic [DCT_NGEN-1:0] pin_out,
  input wire logic [DCT_NGEN-1:0] pin_oe
);
  // ---------------------------------------------------------------
  // Shadow of the run bits, so pin checks know when a channel is idle
  // ---------------------------------------------------------------
  logic [1:0] run_q;
  logic [1:0] run_d;
  always_comb begin
    run_d = run_q;
    if (bus_wr && bus_addr == DCT_IDX_RUN && bus_be[0]) run_d = bus_wdata[2:1];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) run_q <= 2'h0;
    else run_q <= run_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_rst_quiet: assert property (disable iff (1'b0)
    sys_rst |=> bus_rdata == DCT_RD_NONE && pin_oe == 4'h0 && pin_out == 4'h0)
    else $error("outputs not quiet after reset");
  chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  chk_run_unused: assert property (
    bus_rd && bus_addr == DCT_IDX_RUN |=> (bus_rdata & 16'hfff9) == 16'h0000)
    else $error("run register unused bits not zero");
  chk_sync_unused: assert property (
    bus_rd && bus_addr == DCT_IDX_SYNC |=> (bus_rdata & 16'hfff9) == 16'h0000)
    else $error("sync register unused bits not zero");
  chk_stat_fixed: assert property (
    bus_rd && bus_addr == DCT_IDX_STAT1 |=> bus_rdata[15:5] == 11'h006 && bus_rdata[3:2] == 2'h0)
    else $error("status fixed bits wrong");
  chk_unmapped_zero: assert property (bus_rd && bus_addr > 4'hd |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_stop_holds_pin: assert property (
    !run_q[0] && !$past(run_q[0]) && !(bus_wr && bus_addr == DCT_IDX_PIO1)
    |=> $stable(pin_out[1:0]))
    else $error("stopped channel pin moved");
  chk_standby_zero: assert property (
    hw_standby [*6] ##0 (bus_rd && bus_addr == DCT_IDX_CNT1) |=> bus_rdata == DCT_CNT_RST)
    else $error("counter not zero in standby");

  cov_sync_write: cover property (bus_wr && bus_addr == DCT_IDX_SYNC);
  cov_pin_rise: cover property ($rose(pin_out[0]));
  cov_standby_read: cover property (hw_standby && bus_rd);
endmodule : dct_timer_checker

/* dct_pin_src.sv */
`timescale 1ns/10ps
module dct_pin_src
  import dct_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [DCT_NGEN-1:0] edge_req,
  output logic [DCT_NGEN-1:0] pin_lvl
);
  // ---------------------------------------------------------------
  // External pin source; lines rest low as if pulled down
  // ---------------------------------------------------------------
  logic [DCT_NGEN-1:0] lvl_d;
  always_comb lvl_d = edge_req;
  always_ff @(posedge clk) begin
    if (sys_rst) pin_lvl <= '0;
    else pin_lvl <= lvl_d;
  end
endmodule : dct_pin_src

/* tb.sv */
`timescale 1ns/10ps
module tb;
  import dct_pkg::*;
  logic clk, sys_rst, hw_standby, bus_wr, bus_rd;
  logic [3:0] bus_addr, pin_in, pin_out, pin_oe, edge_req;
  logic [1:0] bus_be;
  logic [15:0] bus_wdata, bus_rdata, v, p;
  int error_cnt, tests_run;

  dct_timer dct_timer_inst (.clk(clk), .sys_rst(sys_rst), .hw_standby(hw_standby),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  dct_pin_src dct_pin_src_inst (.clk(clk), .sys_rst(sys_rst), .edge_req(edge_req),
    .pin_lvl(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Bus tasks and checking
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= be;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] r;
    rd(a, r);
    chk(nm, r, e);
  endtask : rc
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    sys_rst = 1'b1;
    hw_standby = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 4'h0;
    bus_be = 2'h0;
    bus_wdata = 16'h0000;
    edge_req = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rc("cnt1", DCT_IDX_CNT1, DCT_CNT_RST);
    rc("cnt2", 4'h1, DCT_CNT_RST);
    for (int i = 0; i < DCT_NGEN; i++) rc("gen", DCT_IDX_GEN0 + 4'(i), DCT_GEN_RST);
    rc("run", DCT_IDX_RUN, 16'h0000);
    rc("sync", DCT_IDX_SYNC, 16'h0000);
    for (int i = 0; i < DCT_NGEN; i++) begin
      wr(DCT_IDX_GEN0 + 4'(i), 16'h1230 + 16'(i));
      rc("gen_rw", DCT_IDX_GEN0 + 4'(i), 16'h1230 + 16'(i));
    end
    wr(DCT_IDX_GEN0, 16'h5555, 2'h1);
    rc("gen_byte", DCT_IDX_GEN0, 16'h1230);
    wr(DCT_IDX_CNT1, 16'h4321);
    rc("cnt_rw", DCT_IDX_CNT1, 16'h4321);
    wr(DCT_IDX_RUN, 16'hffff, 2'h1);
    rc("run_mask", DCT_IDX_RUN, 16'h0006);
    wr(DCT_IDX_RUN, 16'h0000, 2'h1);
    rd(DCT_IDX_CNT1, v);
    repeat (20) @(posedge clk);
    rc("cnt_stop", DCT_IDX_CNT1, v);
    wr(DCT_IDX_SYNC, 16'hffff, 2'h1);
    rc("sync_mask", DCT_IDX_SYNC, 16'h0006);
    wr(DCT_IDX_CNT1, 16'h1234);
    rc("sync_preset", 4'h1, 16'h1234);
    wr(DCT_IDX_SYNC, 16'h0002, 2'h1);
    wr(DCT_IDX_CNT1, 16'h5555);
    rc("indep", 4'h1, 16'h1234);
    // Free run across the wrap at clk/1
    wr(DCT_IDX_CNT1, 16'hfff0);
    wr(DCT_IDX_RUN, 16'h0002, 2'h1);
    repeat (40) @(posedge clk);
    wr(DCT_IDX_RUN, 16'h0000, 2'h1);
    rd(DCT_IDX_STAT1, v);
    chk("ovf", v & 16'hffd0, 16'h00d0);
    rd(DCT_IDX_CNT1, v);
    chk("wrap", v, 16'h001a);
    // Channel 1 clears on match A, channel 2 follows by sync clear
    wr(4'h1, 16'h8000);
    wr(DCT_IDX_CNT1, 16'h0000);
    wr(DCT_IDX_GEN0, 16'h0010);
    wr(DCT_IDX_CTRL1, 16'h0004, 2'h1);
    wr(DCT_IDX_CTRL1 + 4'h1, 16'h000c, 2'h1);
    wr(DCT_IDX_SYNC, 16'h0006, 2'h1);
    wr(DCT_IDX_RUN, 16'h0006, 2'h1);
    repeat (30) @(posedge clk);
    wr(DCT_IDX_RUN, 16'h0000, 2'h1);
    rd(DCT_IDX_CNT1, v);
    rd(4'h1, p);
    chk("sync_clr", p, v);
    chk("clr_range", v, 16'h000f);
    wr(DCT_IDX_PIO1, 16'h0005, 2'h1);
    repeat (2) @(posedge clk);
    chk("pin_init1", {12'h0, pin_out, pin_oe}, 16'h0011);
    wr(DCT_IDX_PIO1, 16'h0006, 2'h1);
    repeat (2) @(posedge clk);
    chk("pin_init0", {12'h0, pin_out, pin_oe}, 16'h0001);
    // One toggle at the first match, then stop before the second
    wr(DCT_IDX_CNT1, 16'h0000);
    wr(DCT_IDX_RUN, 16'h0002, 2'h1);
    repeat (25) @(posedge clk);
    wr(DCT_IDX_RUN, 16'h0000, 2'h1);
    chk("pin_toggle", {12'h0, pin_out}, 16'h0001);
    repeat (30) @(posedge clk);
    chk("pin_hold", {12'h0, pin_out}, 16'h0001);
    wr(DCT_IDX_STAT1, 16'h0000, 2'h1);
    rc("stat_clr", DCT_IDX_STAT1, 16'h00c0);
    // Divide by four, drive low on match A, no counter clear
    wr(DCT_IDX_PIO1, 16'h0003, 2'h1);
    wr(DCT_IDX_GEN0, 16'h0005);
    wr(DCT_IDX_CTRL1, 16'h0001, 2'h1);
    wr(DCT_IDX_CNT1, 16'h0000);
    wr(DCT_IDX_RUN, 16'h0002, 2'h1);
    repeat (38) @(posedge clk);
    wr(DCT_IDX_RUN, 16'h0000, 2'h1);
    rc("div4", DCT_IDX_CNT1, 16'h000a);
    chk("pin_low", {12'h0, pin_out, pin_oe}, 16'h0001);
    wr(DCT_IDX_PIO1, 16'h0008, 2'h1);
    wr(DCT_IDX_CNT1, 16'h0abc);
    @(posedge clk);
    edge_req <= 4'h1;
    repeat (6) @(posedge clk);
    edge_req <= 4'h0;
    rc("capture", DCT_IDX_GEN0, 16'h0abc);
    wr(DCT_IDX_CNT1, 16'h7777);
    rc("cnt_pre", DCT_IDX_CNT1, 16'h7777);
    @(posedge clk);
    hw_standby <= 1'b1;
    repeat (8) @(posedge clk);
    rc("standby", DCT_IDX_CNT1, DCT_CNT_RST);
    @(posedge clk);
    hw_standby <= 1'b0;
    rc("unmapped", 4'he, 16'h0000);
    tally_and_finish;
  end
endmodule : tb

bind dct_timer dct_timer_checker dct_timer_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .hw_standby(hw_standby), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe));
